// *** ebc_boot_loader.sv ***
// boot-time loader: fetches the register image from a serial eeprom as i2c master
// assumes por_done rises once the internal power-up load has finished
`timescale 1ns/1ns
`default_nettype none

// How it works
// - after reset and power-up, contend for bus
// - eeprom bus address taken from startup registers
// - serial control port ignored while loading
// - startup and config registers writable once loading ends
// - nack aborts; unloaded registers keep defaults
// - crc byte at e0 must match computed crc
// - any abort sets load failure flag
// - failure flag drives both loss-of-lock flags
// - retry count adds arbitration attempts, default one
// - otp bit selects full or eight-byte otp load
// - eeprom bit zero disables eeprom load
// - wide addressing bit sends two offset bytes
// - seven-bit field holds eeprom slave address
// - global status block at 021a to 021f
// - image checked with ccitt-8 crc
// - abort on nack, arbitration, collision, crc, timeout
// - start at 100khz, go 400khz on byte 05
// - fixed response timer on each data and ack bit
module ebc_boot_loader (
  // clock and reset
  input wire logic ref_clk,
  input wire logic arst_n,
  // power-up sequencing
  input wire logic por_done,
  output logic otp_full_load,
  output logic boot_busy,
  // serial control port register access
  input wire logic reg_req,
  input wire logic reg_wr,
  input wire logic [ebc_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  output logic reg_ack,
  // status
  output logic load_failure_flag,
  output logic [1:0] loss_of_lock_flag,
  // i2c lines, open drain
  input wire logic scl_in,
  output logic scl_out,
  output logic scl_oe,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe
);
  import ebc_pkg::*;

  typedef enum logic [3:0] {
    M_WAIT_POR, M_CHECK, M_START, M_ADDR_W, M_OFS_HI, M_OFS_LO,
    M_RESTART, M_ADDR_R, M_READ, M_STOP, M_ABORT, M_DONE
  } ebc_main_state_t;

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic [7:0] ebc_addr_byte(input logic [6:0] dev, input logic rd);
    ebc_addr_byte = {dev, rd};
  endfunction

  function automatic logic ebc_in_cfg(input logic [ADDR_W-1:0] a);
    ebc_in_cfg = (a[9:8] == 2'b00) && (a[7:0] >= CFG_FIRST_B) && (a[7:0] <= CFG_LAST_B);
  endfunction

  function automatic logic [7:0] ebc_crc8(input logic [7:0] crc, input logic [7:0] data);
    logic [7:0] c;
    c = crc ^ data;
    for (int i = 0; i < 8; i++) begin
      c = c[7] ? ((c << 1) ^ CRC_POLY) : (c << 1);
    end
    ebc_crc8 = c;
  endfunction

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  ebc_i2c_if bus ();

  ebc_main_state_t state_reg;
  logic pend_reg;
  logic [RTY_W-1:0] retry_reg;
  logic [7:0] idx_reg;
  logic [7:0] crc_reg;
  logic crc_bad_reg;
  logic fail_set_reg;
  logic [7:0] startup_boot_control_reg;
  logic [7:0] eeprom_address_config_reg;
  logic [7:0] cfg_mem [CFG_FIRST:CFG_LAST];
  logic bus_state;
  ebc_op_t op_next;
  logic [7:0] data_next;
  logic port_ok;
  logic port_wr;
  logic [7:0] rdata_next;

  // ---------------------------------------------------------------
  // bus engine
  // ---------------------------------------------------------------
  ebc_i2c_engine u_engine (
    .ref_clk(ref_clk),
    .arst_n(arst_n),
    .bus(bus.engine),
    .scl_in(scl_in),
    .sda_in(sda_in),
    .scl_oe(scl_oe),
    .sda_oe(sda_oe)
  );

  // ---------------------------------------------------------------
  // command selection per sequencer state
  // ---------------------------------------------------------------
  always_comb begin
    bus_state = 1'b1;
    op_next = OP_WRITE;
    data_next = 8'h00;
    case (state_reg)
      M_START, M_RESTART: op_next = OP_START;
      M_ADDR_W: data_next = ebc_addr_byte(eeprom_address_config_reg[6:0], 1'b0);
      M_ADDR_R: data_next = ebc_addr_byte(eeprom_address_config_reg[6:0], 1'b1);
      M_OFS_HI, M_OFS_LO: data_next = 8'h00;
      M_READ: op_next = OP_READ;
      M_STOP, M_ABORT: op_next = OP_STOP;
      default: bus_state = 1'b0;
    endcase
  end

  // ---------------------------------------------------------------
  // boot sequencer
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_reg <= M_WAIT_POR;
      pend_reg <= 1'b0;
      retry_reg <= '0;
      idx_reg <= 8'h00;
      crc_reg <= CRC_INIT;
      crc_bad_reg <= 1'b0;
      fail_set_reg <= 1'b0;
      boot_busy <= 1'b1;
      bus.cmd_valid <= 1'b0;
      bus.cmd_op <= OP_START;
      bus.cmd_data <= 8'h00;
      bus.cmd_ack <= 1'b0;
      bus.fast <= 1'b0;
    end else begin
      bus.cmd_valid <= 1'b0;
      fail_set_reg <= 1'b0;
      if (state_reg == M_WAIT_POR) begin
        if (por_done) begin
          state_reg <= M_CHECK;
        end
      end else if (state_reg == M_CHECK) begin
        retry_reg <= startup_boot_control_reg[RTY_LSB +: RTY_W];
        idx_reg <= 8'h00;
        crc_reg <= CRC_INIT;
        crc_bad_reg <= 1'b0;
        bus.fast <= 1'b0;
        if (startup_boot_control_reg[EEP_DISABLE_BIT]) begin
          state_reg <= M_DONE;
        end else begin
          state_reg <= M_START;
        end
      end else if (state_reg == M_DONE) begin
        boot_busy <= 1'b0;
      end else if (bus_state && !pend_reg) begin
        pend_reg <= 1'b1;
        bus.cmd_valid <= 1'b1;
        bus.cmd_op <= op_next;
        bus.cmd_data <= data_next;
        bus.cmd_ack <= (idx_reg != IMG_CRC_OFS);
      end else if (bus.rsp_done) begin
        pend_reg <= 1'b0;
        if (bus.rsp_timeout) begin
          fail_set_reg <= 1'b1;
          state_reg <= M_DONE;
        end else if (bus.rsp_arb_lost) begin
          if (retry_reg != '0) begin
            retry_reg <= retry_reg - 1'b1;
            idx_reg <= 8'h00;
            crc_reg <= CRC_INIT;
            bus.fast <= 1'b0;
            state_reg <= M_START;
          end else begin
            fail_set_reg <= 1'b1;
            state_reg <= M_DONE;
          end
        end else if (bus.rsp_nack) begin
          state_reg <= M_ABORT;
        end else begin
          case (state_reg)
            M_START: state_reg <= M_ADDR_W;
            M_ADDR_W: begin
              if (eeprom_address_config_reg[WIDE_ADDR_BIT]) begin
                state_reg <= M_OFS_HI;
              end else begin
                state_reg <= M_OFS_LO;
              end
            end
            M_OFS_HI: state_reg <= M_OFS_LO;
            M_OFS_LO: state_reg <= M_RESTART;
            M_RESTART: state_reg <= M_ADDR_R;
            M_ADDR_R: state_reg <= M_READ;
            M_READ: begin
              crc_reg <= ebc_crc8(crc_reg, bus.rsp_data);
              if (idx_reg == IMG_SPEED_OFS && bus.rsp_data[SPEED_BIT]) begin
                bus.fast <= 1'b1;
              end
              if (idx_reg == IMG_CRC_OFS) begin
                crc_bad_reg <= (bus.rsp_data != crc_reg);
                state_reg <= M_STOP;
              end else begin
                idx_reg <= idx_reg + 8'h01;
              end
            end
            M_STOP: begin
              fail_set_reg <= crc_bad_reg;
              state_reg <= M_DONE;
            end
            M_ABORT: begin
              fail_set_reg <= 1'b1;
              state_reg <= M_DONE;
            end
            default: state_reg <= M_DONE;
          endcase
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // serial control port
  // ---------------------------------------------------------------
  assign port_ok = reg_req && !boot_busy;
  assign port_wr = port_ok && reg_wr;

  always_comb begin
    rdata_next = 8'h00;
    if (reg_addr == REG_STARTUP_BOOT_CTRL) begin
      rdata_next = startup_boot_control_reg;
    end else if (reg_addr == REG_EEPROM_ADDR_CFG) begin
      rdata_next = eeprom_address_config_reg;
    end else if (ebc_in_cfg(reg_addr)) begin
      rdata_next = cfg_mem[reg_addr[7:0]];
    end else if (reg_addr == REG_GSTAT_BOOT) begin
      rdata_next[LOAD_FAIL_BIT] = load_failure_flag;
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      reg_ack <= 1'b0;
      reg_rdata <= 8'h00;
    end else begin
      reg_ack <= port_ok;
      if (port_ok) begin
        reg_rdata <= rdata_next;
      end
    end
  end

  // startup control registers
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      startup_boot_control_reg <= STARTUP_BOOT_CTRL_RST;
      eeprom_address_config_reg <= EEPROM_ADDR_CFG_RST;
    end else if (port_wr) begin
      if (reg_addr == REG_STARTUP_BOOT_CTRL) begin
        startup_boot_control_reg <= reg_wdata;
      end
      if (reg_addr == REG_EEPROM_ADDR_CFG) begin
        eeprom_address_config_reg <= reg_wdata;
      end
    end
  end

  // loaded configuration bytes, one flop group per address
  for (genvar g = CFG_FIRST; g <= CFG_LAST; g++) begin : g_cfg
    always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
        cfg_mem[g] <= CFG_REG_RST;
      end else if (state_reg == M_READ && bus.rsp_done && pend_reg && !bus.rsp_arb_lost
                   && !bus.rsp_timeout && idx_reg == 8'(g)) begin
        cfg_mem[g] <= bus.rsp_data;
      end else if (port_wr && reg_addr == ADDR_W'(g)) begin
        cfg_mem[g] <= reg_wdata;
      end
    end
  end

  // ---------------------------------------------------------------
  // status and indicator outputs
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      load_failure_flag <= 1'b0;
    end else if (fail_set_reg) begin
      load_failure_flag <= 1'b1;
    end else if (port_wr && reg_addr == REG_GSTAT_BOOT && reg_wdata[LOAD_FAIL_BIT]) begin
      load_failure_flag <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      loss_of_lock_flag <= 2'h0;
      otp_full_load <= 1'b1;
      scl_out <= 1'b0;
      sda_out <= 1'b0;
    end else begin
      loss_of_lock_flag <= {2{load_failure_flag}};
      otp_full_load <= !startup_boot_control_reg[OTP_PARTIAL_BIT];
      scl_out <= 1'b0;
      sda_out <= 1'b0;
    end
  end

endmodule // ebc_boot_loader

`default_nettype wire

// *** ebc_pkg.sv ***
// constants, field layouts and types for the eeprom boot configuration loader
// assumes a 10 MHz ref_clk and a byte-wide register port with 10-bit addresses
`default_nettype none

package ebc_pkg;

  // ---------------------------------------------------------------
  // register map
  // ---------------------------------------------------------------
  localparam int ADDR_W = 10;
  localparam logic [ADDR_W-1:0] REG_STARTUP_BOOT_CTRL = 10'h000;
  localparam logic [ADDR_W-1:0] REG_EEPROM_ADDR_CFG = 10'h001;
  localparam logic [ADDR_W-1:0] REG_GSTAT_FIRST = 10'h21a;
  localparam logic [ADDR_W-1:0] REG_GSTAT_LAST = 10'h21f;
  localparam logic [ADDR_W-1:0] REG_GSTAT_BOOT = 10'h21e;
  localparam int CFG_FIRST = 8;
  localparam int CFG_LAST = 223;
  localparam logic [7:0] CFG_FIRST_B = 8'h08;
  localparam logic [7:0] CFG_LAST_B = 8'hdf;

  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int RTY_LSB = 3;
  localparam int RTY_W = 5;
  localparam int OTP_PARTIAL_BIT = 1;
  localparam int EEP_DISABLE_BIT = 0;
  localparam int WIDE_ADDR_BIT = 7;
  localparam int LOAD_FAIL_BIT = 0;
  localparam int SPEED_BIT = 0;

  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [7:0] STARTUP_BOOT_CTRL_RST = 8'h08;
  localparam logic [7:0] EEPROM_ADDR_CFG_RST = 8'h50;
  localparam logic [7:0] CFG_REG_RST = 8'h00;

  // ---------------------------------------------------------------
  // eeprom image layout
  // ---------------------------------------------------------------
  localparam logic [7:0] IMG_SPEED_OFS = 8'h05;
  localparam logic [7:0] IMG_CRC_OFS = 8'he0;
  localparam logic [7:0] CRC_POLY = 8'h07;
  localparam logic [7:0] CRC_INIT = 8'h00;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int CLK_HZ = 10_000_000;
  localparam int SLOW_HZ = 100_000;
  localparam int FAST_HZ = 400_000;
  localparam int QTR_SLOW_CYC = (CLK_HZ + 4 * SLOW_HZ - 1) / (4 * SLOW_HZ);
  localparam int QTR_FAST_CYC = (CLK_HZ + 4 * FAST_HZ - 1) / (4 * FAST_HZ);
  localparam int QTR_W = 5;
  localparam int RESP_TIMEOUT_US = 25;
  localparam int RESP_TIMEOUT_CYC = RESP_TIMEOUT_US * (CLK_HZ / 1_000_000);
  localparam int TO_W = 9;

  // ---------------------------------------------------------------
  // bus engine commands
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    OP_START,
    OP_WRITE,
    OP_READ,
    OP_STOP
  } ebc_op_t;

endpackage

`default_nettype wire

// *** ebc_i2c_if.sv ***
// command and response bundle between the boot sequencer and the bus engine
// assumes both ends run on ref_clk; commands are one-cycle pulses
`timescale 1ns/1ns
`default_nettype none

interface ebc_i2c_if;
  import ebc_pkg::*;
  logic cmd_valid;
  ebc_op_t cmd_op;
  logic [7:0] cmd_data;
  logic cmd_ack;
  logic fast;
  logic rsp_done;
  logic [7:0] rsp_data;
  logic rsp_nack;
  logic rsp_arb_lost;
  logic rsp_timeout;

  modport ctrl (
    output cmd_valid, cmd_op, cmd_data, cmd_ack, fast,
    input rsp_done, rsp_data, rsp_nack, rsp_arb_lost, rsp_timeout
  );
  modport engine (
    input cmd_valid, cmd_op, cmd_data, cmd_ack, fast,
    output rsp_done, rsp_data, rsp_nack, rsp_arb_lost, rsp_timeout
  );
endinterface : ebc_i2c_if

`default_nettype wire

// *** ebc_i2c_engine.sv ***
// multi-master i2c bit engine: start, byte write, byte read, stop
// assumes open-drain pins resolved outside; clock stretching accepted up to the response timeout
`timescale 1ns/1ns
`default_nettype none

module ebc_i2c_engine (
  // clock and reset
  input wire logic ref_clk,
  input wire logic arst_n,
  // command side
  ebc_i2c_if.engine bus,
  // bus lines
  input wire logic scl_in,
  input wire logic sda_in,
  output logic scl_oe,
  output logic sda_oe
);
  import ebc_pkg::*;

  typedef enum logic [1:0] {E_IDLE, E_START, E_BIT, E_STOP} ebc_eng_state_t;

  ebc_eng_state_t state_reg;
  logic [1:0] phase_reg;
  logic [3:0] bit_reg;
  logic [7:0] sh_reg;
  logic rd_reg;
  logic ack_reg;
  logic [QTR_W-1:0] qcnt_reg;
  logic [TO_W-1:0] to_reg;
  logic tick;

  assign tick = (qcnt_reg == '0);

  // ---------------------------------------------------------------
  // quarter-bit divider
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      qcnt_reg <= '0;
    end else if (state_reg == E_IDLE || tick) begin
      qcnt_reg <= bus.fast ? QTR_W'(QTR_FAST_CYC - 1) : QTR_W'(QTR_SLOW_CYC - 1);
    end else begin
      qcnt_reg <= qcnt_reg - 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // bit sequencing
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_reg <= E_IDLE;
      phase_reg <= 2'h0;
      bit_reg <= 4'h0;
      sh_reg <= 8'h00;
      rd_reg <= 1'b0;
      ack_reg <= 1'b0;
      to_reg <= '0;
      scl_oe <= 1'b0;
      sda_oe <= 1'b0;
      bus.rsp_done <= 1'b0;
      bus.rsp_data <= 8'h00;
      bus.rsp_nack <= 1'b0;
      bus.rsp_arb_lost <= 1'b0;
      bus.rsp_timeout <= 1'b0;
    end else begin
      bus.rsp_done <= 1'b0;
      case (state_reg)
        E_IDLE: begin
          if (bus.cmd_valid) begin
            bus.rsp_nack <= 1'b0;
            bus.rsp_arb_lost <= 1'b0;
            bus.rsp_timeout <= 1'b0;
            sh_reg <= bus.cmd_data;
            rd_reg <= (bus.cmd_op == OP_READ);
            ack_reg <= bus.cmd_ack;
            phase_reg <= 2'h0;
            bit_reg <= 4'h0;
            case (bus.cmd_op)
              OP_START: state_reg <= E_START;
              OP_STOP: state_reg <= E_STOP;
              default: state_reg <= E_BIT;
            endcase
          end
        end
        E_START: begin
          if (tick) begin
            phase_reg <= phase_reg + 2'h1;
            case (phase_reg)
              2'h0: begin
                scl_oe <= 1'b0;
                sda_oe <= 1'b0;
              end
              2'h1: begin
                if (!sda_in || !scl_in) begin
                  // another master owns the bus
                  bus.rsp_arb_lost <= 1'b1;
                  bus.rsp_done <= 1'b1;
                  state_reg <= E_IDLE;
                end else begin
                  sda_oe <= 1'b1;
                end
              end
              default: begin
                scl_oe <= 1'b1;
                bus.rsp_done <= 1'b1;
                state_reg <= E_IDLE;
              end
            endcase
          end
        end
        E_BIT: begin
          if (phase_reg == 2'h2 && !scl_in) begin
            // scl held low by someone else: bounded wait only
            if (to_reg == TO_W'(RESP_TIMEOUT_CYC - 1)) begin
              bus.rsp_timeout <= 1'b1;
              bus.rsp_done <= 1'b1;
              scl_oe <= 1'b0;
              sda_oe <= 1'b0;
              state_reg <= E_IDLE;
            end else begin
              to_reg <= to_reg + 1'b1;
            end
          end else if (tick) begin
            case (phase_reg)
              2'h0: begin
                sda_oe <= (bit_reg < 4'h8) ? (!rd_reg && !sh_reg[7]) : (rd_reg && ack_reg);
                phase_reg <= 2'h1;
              end
              2'h1: begin
                scl_oe <= 1'b0;
                to_reg <= '0;
                phase_reg <= 2'h2;
              end
              2'h2: begin
                phase_reg <= 2'h3;
                if (bit_reg < 4'h8) begin
                  sh_reg <= {sh_reg[6:0], sda_in};
                  if (!rd_reg && sh_reg[7] && !sda_in) begin
                    // released a one but saw a zero: collision
                    bus.rsp_arb_lost <= 1'b1;
                    bus.rsp_done <= 1'b1;
                    scl_oe <= 1'b0;
                    sda_oe <= 1'b0;
                    state_reg <= E_IDLE;
                  end
                end else if (!rd_reg) begin
                  bus.rsp_nack <= sda_in;
                end
              end
              default: begin
                scl_oe <= 1'b1;
                phase_reg <= 2'h0;
                bit_reg <= bit_reg + 4'h1;
                if (bit_reg == 4'h8) begin
                  sda_oe <= 1'b0;
                  bus.rsp_data <= sh_reg;
                  bus.rsp_done <= 1'b1;
                  state_reg <= E_IDLE;
                end
              end
            endcase
          end
        end
        E_STOP: begin
          if (tick) begin
            phase_reg <= phase_reg + 2'h1;
            case (phase_reg)
              2'h0: begin
                scl_oe <= 1'b1;
                sda_oe <= 1'b1;
              end
              2'h1: scl_oe <= 1'b0;
              default: begin
                sda_oe <= 1'b0;
                bus.rsp_done <= 1'b1;
                state_reg <= E_IDLE;
              end
            endcase
          end
        end
        default: state_reg <= E_IDLE;
      endcase
    end
  end

endmodule // ebc_i2c_engine

`default_nettype wire

// *** ebc_checker.sv ***
// assertions on the boot loader's top ports
// assumes a bind onto ebc_boot_loader, one clock domain
`timescale 1ns/1ns
`default_nettype none
module ebc_checker (
  // clock and reset
  input wire logic ref_clk,
  input wire logic arst_n,
  // watched ports
  input wire logic por_done,
  input wire logic boot_busy,
  input wire logic reg_req,
  input wire logic reg_wr,
  input wire logic [ebc_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_ack,
  input wire logic load_failure_flag,
  input wire logic [1:0] loss_of_lock_flag,
  input wire logic scl_oe,
  input wire logic sda_oe
);
  import ebc_pkg::*;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!arst_n);
  property p_ack; reg_req && !boot_busy |=> reg_ack; endproperty
  a_ack: assert property (p_ack) else $error("access not acknowledged");
  property p_ign; boot_busy |=> !reg_ack; endproperty
  a_ign: assert property (p_ign) else $error("access answered while busy");
  property p_cause; reg_ack |-> $past(reg_req) && !$past(boot_busy); endproperty
  a_cause: assert property (p_cause) else $error("ack without request");
  property p_wait; !por_done |-> boot_busy && !scl_oe && !sda_oe; endproperty
  a_wait: assert property (p_wait) else $error("bus used before power-up");
  property p_rel; $fell(boot_busy) |-> !scl_oe && !sda_oe; endproperty
  a_rel: assert property (p_rel) else $error("bus held after load");
  property p_abort; $rose(load_failure_flag) |-> ##[0:400] !boot_busy; endproperty
  a_abort: assert property (p_abort) else $error("load not ended");
  property p_lock; 1'b1 |=> loss_of_lock_flag == {2{$past(load_failure_flag)}}; endproperty
  a_lock: assert property (p_lock) else $error("lock flags wrong");
  property p_keep;
    load_failure_flag && !(reg_req && reg_wr && !boot_busy && reg_addr == REG_GSTAT_BOOT
      && reg_wdata[0]) |=> load_failure_flag;
  endproperty
  a_keep: assert property (p_keep) else $error("failure flag lost");
endmodule // ebc_checker
`default_nettype wire

// *** ebc_eeprom_model.sv ***
// behavioural serial eeprom slave holding the boot image
// assumes pull-up lines resolved by the bench
`timescale 1ns/1ns
`default_nettype none
module ebc_eeprom_model (
  // bus lines
  input wire logic scl,
  input wire logic sda,
  // refuse every byte
  input wire logic nack,
  // pull sda low
  output logic sda_oe
);
  logic [7:0] mem [0:255];
  logic [7:0] sr, d, ptr, c;
  logic adr, rd, tx, mack;
  int bc, i;
  initial begin
    c = 8'h00;
    for (i = 0; i < 224; i++) begin
      mem[i] = i < 6 ? 8'hff : i == 6 ? 8'hab : i == 7 ? 8'h00 : 8'(i) ^ 8'h5a;
      c ^= mem[i];
      repeat (8) c = c[7] ? {c[6:0], 1'b0} ^ 8'h07 : {c[6:0], 1'b0};
    end
    mem[224] = c;
    sda_oe = 0;
    {adr, rd, tx, bc, ptr} = '0;
  end
  always @(negedge sda) if (scl) begin
    bc = 0;
    adr = 1;
    tx = 0;
  end
  always @(posedge scl) begin
    if (bc == 8) mack = sda;
    else sr = {sr[6:0], sda};
    bc++;
  end
  always @(negedge scl) begin
    if (bc == 8) begin
      sda_oe = !tx && !nack && !(adr && sr[7:1] != 7'h50);
      if (adr) rd = sr[0];
      else if (!tx) ptr = sr;
      adr = 0;
    end else if (bc == 9) begin
      bc = 0;
      tx = rd && !(tx && mack);
      d = mem[ptr];
      if (tx) ptr++;
      sda_oe = tx && !d[7];
    end else if (tx) sda_oe = !d[7 - bc];
  end
endmodule // ebc_eeprom_model
`default_nettype wire

// *** ebc_tb.sv ***
// bench for the boot loader: refused load, lost arbitration, then full image load
// assumes pull-ups on both bus lines
`timescale 1ns/1ns
`default_nettype none
module tb;
  import ebc_pkg::*;
  logic ref_clk = 1'h0, arst_n = 1'h0, por_done = 1'h0, reg_req = 1'h0, reg_wr = 1'h0, nack;
  logic [ADDR_W-1:0] reg_addr = 10'h000;
  logic [7:0] reg_wdata = 8'h00, reg_rdata;
  logic reg_ack, otp_full_load, boot_busy, load_failure_flag, scl_out, sda_out;
  logic scl_oe, sda_oe, m_oe, scl, sda, hold = 1'h0;
  logic [1:0] loss_of_lock_flag;
  int error_cnt = 0, checks = 0, cyc = 0, i;
  assign scl = !(scl_oe || hold);
  assign sda = !(sda_oe || m_oe);
  ebc_boot_loader u_ebc_boot_loader (.ref_clk, .arst_n, .por_done, .otp_full_load, .boot_busy,
    .reg_req, .reg_wr, .reg_addr, .reg_wdata, .reg_rdata, .reg_ack, .load_failure_flag,
    .loss_of_lock_flag, .scl_in(scl), .scl_out, .scl_oe, .sda_in(sda), .sda_out, .sda_oe);
  ebc_eeprom_model u_ebc_eeprom_model (.scl, .sda, .nack, .sda_oe(m_oe));
  initial forever #50 ref_clk = ~ref_clk;
  always @(posedge ref_clk) if (++cyc == 90000) begin
    error_cnt++;
    results();
  end
  task automatic results();
    if (error_cnt == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH %s exp %h got %h", nm, exp, got);
    end
  endtask
  task automatic acc(input logic wr, input logic [ADDR_W-1:0] a, input logic [7:0] d);
    @(negedge ref_clk);
    {reg_req, reg_wr, reg_addr, reg_wdata} = {1'h1, wr, a, d};
    @(negedge ref_clk);
    reg_req = 1'h0;
  endtask
  task automatic rd(input logic [ADDR_W-1:0] a, input logic [7:0] exp);
    acc(1'h0, a, 8'h00);
    chk("ack", 8'h01, {7'h00, reg_ack});
    chk($sformatf("reg %h", a), exp, reg_rdata);
  endtask
  task automatic boot(input logic n);
    {arst_n, por_done, nack} = {1'h0, 1'h0, n};
    repeat (4) @(negedge ref_clk);
    arst_n = 1'h1;
    acc(1'h1, 10'h008, 8'hff);
    chk("busy ack", 8'h00, {7'h00, reg_ack});
    por_done = 1'h1;
    while (boot_busy !== 1'h0) @(negedge ref_clk);
    @(negedge ref_clk);
  endtask
  task automatic t_nack();
    boot(1'h1);
    chk("fail", 8'h01, {7'h00, load_failure_flag});
    chk("lock", 8'h03, {6'h00, loss_of_lock_flag});
    chk("otp", 8'h01, {7'h00, otp_full_load});
    chk("outs", 8'h00, {6'h00, scl_out, sda_out});
    rd(10'h008, 8'h00);
    rd(REG_GSTAT_BOOT, 8'h01);
    rd(10'h000, 8'h08);
    rd(10'h001, 8'h50);
    acc(1'h1, REG_GSTAT_BOOT, 8'h01);
    rd(REG_GSTAT_BOOT, 8'h00);
    acc(1'h1, 10'h008, 8'ha5);
    rd(10'h008, 8'ha5);
    acc(1'h1, 10'h000, 8'h0a);
    @(negedge ref_clk);
    chk("otp part", 8'h00, {7'h00, otp_full_load});
    rd(10'h000, 8'h0a);
  endtask
  task automatic t_arb();
    hold = 1'h1;
    boot(1'h0);
    hold = 1'h0;
    chk("arb fail", 8'h01, {7'h00, load_failure_flag});
    rd(10'h008, 8'h00);
  endtask
  task automatic t_load();
    boot(1'h0);
    chk("no fail", 8'h00, {7'h00, load_failure_flag});
    for (i = 8; i < 224; i++) rd(10'(i), 8'(i) ^ 8'h5a);
    rd(10'h300, 8'h00);
  endtask
  initial begin
    t_nack();
    t_arb();
    t_load();
    results();
  end
endmodule // tb
bind ebc_boot_loader ebc_checker u_ebc_checker (.ref_clk, .arst_n, .por_done, .boot_busy,
  .reg_req, .reg_wr, .reg_addr, .reg_wdata, .reg_ack, .load_failure_flag, .loss_of_lock_flag,
  .scl_oe, .sda_oe);
`default_nettype wire
